// ===== dv/rre_exec_checker.sv
// port assertions for the return and rotate execution unit
`default_nettype none
module rre_exec_checker #(
  parameter int unsigned     PC_W    = 10,
  parameter logic [PC_W-1:0] IRQ_VEC = '0
) (
  input wire logic              sys_clk,
  input wire logic              srst,
  input wire logic              op_valid,
  input wire rre_pkg::rre_op_t  op_code,
  input wire logic [7:0]        mem_rdata,
  input wire logic              busy,
  input wire logic              done,
  input wire logic              mem_rd,
  input wire logic              mem_wr,
  input wire logic [7:0]        mem_wdata,
  input wire logic              stack_pop,
  input wire logic              stack_push,
  input wire logic              pc_load,
  input wire logic [PC_W-1:0]   pc_value,
  input wire logic              irq_ack,
  input wire logic [7:0]        working_register,
  input wire logic              carry_flag,
  input wire logic              master_irq_enable
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  logic [2:0] op_q;
  logic [7:0] rd_q;
  wire        acc = op_valid && !busy && op_code != rre_pkg::RRE_OP_NONE;
  always_ff @(posedge sys_clk) begin
    if (acc) begin
      op_q <= op_code;
    end
  end
  // read data is consumed one cycle before the result shows
  always_ff @(posedge sys_clk) begin
    rd_q <= mem_rdata;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  sequence s_acc_rot;
    acc && op_code inside {[3'h2:3'h6]};
  endsequence
  sequence s_rot_walk;
    mem_rd ##1 !done ##1 done ##1 !busy;
  endsequence
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_rot_walk_ok: assert property (s_acc_rot |=> s_rot_walk)
    else $error("rotate sequence out of step");
  a_ret_lit_pop: assert property (acc && op_code == rre_pkg::RRE_OP_RET_LIT
    |=> stack_pop ##1 pc_load && done) else $error("literal return steps wrong");
  a_rl_mem_val: assert property (mem_wr && op_q == rre_pkg::RRE_OP_RL_MEM
    |-> mem_wdata == {rd_q[6:0], rd_q[7]} && $stable(carry_flag)) else $error("left rotate wrong");
  a_rr_mem_val: assert property (mem_wr && op_q == rre_pkg::RRE_OP_RR_MEM
    |-> mem_wdata == {rd_q[0], rd_q[7:1]} && $stable(carry_flag))
    else $error("right rotate wrong");
  a_rlc_mem_val: assert property (mem_wr && op_q == rre_pkg::RRE_OP_RLC_MEM
    |-> mem_wdata == {rd_q[6:0], $past(carry_flag)} && carry_flag == rd_q[7])
    else $error("carry rotate wrong");
  a_rl_wr_val: assert property (done && op_q == rre_pkg::RRE_OP_RL_WR
    |-> working_register == {rd_q[6:0], rd_q[7]} && !mem_wr && $stable(carry_flag))
    else $error("rotate to working wrong");
  a_rlc_wr_val: assert property (done && op_q == rre_pkg::RRE_OP_RLC_WR
    |-> carry_flag == rd_q[7] && !mem_wr
    && working_register == {rd_q[6:0], $past(carry_flag)})
    else $error("carry rotate to working wrong");
  a_irq_enable_set: assert property (pc_load && !irq_ack
    && op_q == rre_pkg::RRE_OP_RET_IRQ |-> master_irq_enable)
    else $error("enable not set on return");
  a_irq_entry_ok: assert property (irq_ack |-> pc_load && stack_push && done
    && pc_value == IRQ_VEC && !master_irq_enable) else $error("pending entry wrong");
endmodule
`default_nettype wire

// ===== dv/test_rre_exec.sv
// self-checking bench for the return and rotate execution unit
`default_nettype none
module test_rre_exec;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [9:0] VEC = 10'h0a0;
  logic             sys_clk, srst, op_valid, irq_pending, carry_wr, carry_wdata, working_wr;
  rre_pkg::rre_op_t op_code;
  logic [7:0]       op_imm, op_addr, mem_rdata, working_wdata;
  logic [7:0]       mem_addr, mem_wdata, working_register;
  logic [9:0]       stack_top, stack_push_data, pc_value;
  logic             busy, done, mem_rd, mem_wr, stack_pop, stack_push, pc_load, irq_ack;
  logic             carry_flag, master_irq_enable, c;
  logic [7:0]       w;
  int               error_cnt, n_compared;
  rre_exec #(.IRQ_VEC(VEC)) u_rre_exec (.sys_clk, .srst, .op_valid, .op_code, .op_imm, .op_addr,
    .mem_rdata, .stack_top, .irq_pending, .carry_wr, .carry_wdata, .working_wr, .working_wdata,
    .busy, .done, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .stack_pop, .stack_push,
    .stack_push_data, .pc_load, .pc_value, .irq_ack, .working_register, .carry_flag,
    .master_irq_enable);
  always #4 sys_clk = ~sys_clk;
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  function automatic logic [8:0] rot(rre_pkg::rre_op_t op, logic [7:0] d, logic ci);
    case (op)
      rre_pkg::RRE_OP_RR_MEM: return {ci, d[0], d[7:1]};
      rre_pkg::RRE_OP_RLC_MEM, rre_pkg::RRE_OP_RLC_WR: return {d[7], d[6:0], ci};
      default: return {ci, d[6:0], d[7]};
    endcase
  endfunction
  // side writes give the carry and working model fresh values
  task automatic ext();
    @(negedge sys_clk);
    working_wr = 1;
    carry_wr = 1;
    working_wdata = 8'($urandom);
    carry_wdata = 1'($urandom);
    @(negedge sys_clk);
    working_wr = 0;
    carry_wr = 0;
    w = working_wdata;
    c = carry_wdata;
  endtask
  task automatic run(rre_pkg::rre_op_t op, logic [7:0] d, logic pend);
    logic [8:0] r;
    logic [9:0] top;
    logic       wr;
    int         k;
    top = 10'($urandom);
    r = rot(op, d, c);
    wr = op == rre_pkg::RRE_OP_RL_WR || op == rre_pkg::RRE_OP_RLC_WR;
    @(negedge sys_clk);
    op_valid = 1;
    op_code = op;
    op_imm = 8'($urandom);
    op_addr = 8'($urandom);
    // request stays up a second cycle while busy, which must be ignored
    @(negedge sys_clk);
    mem_rdata = d;
    stack_top = top;
    irq_pending = pend;
    @(negedge sys_clk);
    op_valid = 0;
    k = 0;
    // look at the pulses mid-cycle, away from the edge that launches them
    while (done !== 1'b1 && k < 8) begin
      @(negedge sys_clk);
      k++;
    end
    chk("done", done, 1);
    mem_rdata = ~d;
    stack_top = ~top;
    irq_pending = 0;
    pend = pend && op == rre_pkg::RRE_OP_RET_IRQ;
    if (op >= rre_pkg::RRE_OP_RL_MEM) begin
      c = r[8];
      if (wr) w = r[7:0];
      else chk("mem_wdata", mem_wdata, r[7:0]);
      chk("mem_wr", mem_wr, !wr);
      chk("mem_addr", mem_addr, op_addr);
    end else begin
      if (op == rre_pkg::RRE_OP_RET_LIT) w = op_imm;
      chk("pc_value", pc_value, pend ? VEC : top);
      chk("pc_load", pc_load, 1);
      chk("irq_ack", irq_ack, pend);
      if (pend) chk("push_data", stack_push_data, top);
      if (op == rre_pkg::RRE_OP_RET_IRQ) chk("mie", master_irq_enable, !pend);
    end
    chk("working", working_register, w);
    chk("carry", carry_flag, c);
    $display("op %0d checked", op);
  endtask
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    {sys_clk, op_valid, irq_pending, carry_wr, carry_wdata, working_wr} = '0;
    {op_imm, op_addr, mem_rdata, working_wdata, stack_top} = '0;
    op_code = rre_pkg::RRE_OP_NONE;
    srst = 1;
    w = 0;
    c = 0;
    void'($urandom(18));
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    srst = 0;
    op_valid = 1;
    @(negedge sys_clk);
    op_valid = 0;
    chk("busy", busy, 0);
    for (int i = 0; i < 7; i++) begin
      ext();
      run(rre_pkg::rre_op_t'(i), 8'h81, i == 1);
    end
    repeat (40) begin
      ext();
      run(rre_pkg::rre_op_t'($urandom_range(6)), 8'($urandom), 1'($urandom));
    end
    end_of_test();
  end
  initial begin
    #20000;
    error_cnt++;
    end_of_test();
  end
endmodule
bind rre_exec rre_exec_checker #(.PC_W(PC_W), .IRQ_VEC(IRQ_VEC)) u_rre_exec_checker (.sys_clk,
  .srst, .op_valid, .op_code, .mem_rdata, .busy, .done, .mem_rd, .mem_wr, .mem_wdata, .stack_pop,
  .stack_push, .pc_load, .pc_value, .irq_ack, .working_register, .carry_flag, .master_irq_enable);
`default_nettype wire

// ===== src/rre_exec.sv
// return and rotate execution unit of the core
//
// Overview of operation
// - literal return pops pc, loads working register
// - interrupt return pops pc, sets master enable
// - pending interrupt serviced on interrupt return, before main program resumes
// - left rotate memory, bit7 to bit0, flags kept
// - left rotate into working register, memory kept
// - left rotate through carry, written to memory
// - left through carry into working, carry updated
// - right rotate memory, bit0 to bit7, flags kept
`include "rre_map.svh"
`default_nettype none

module rre_exec #(
  parameter int unsigned           PC_W    = `RRE_PC_W,
  parameter int unsigned           ADDR_W  = `RRE_ADDR_W,
  parameter logic [`RRE_PC_W-1:0]  IRQ_VEC = `RRE_IRQ_VEC
) (
  input  wire logic                sys_clk,
  input  wire logic                srst,
  input  wire logic                op_valid,
  input  wire rre_pkg::rre_op_t    op_code,
  input  wire logic [7:0]          op_imm,
  input  wire logic [ADDR_W-1:0]   op_addr,
  input  wire logic [7:0]          mem_rdata,
  input  wire logic [PC_W-1:0]     stack_top,
  input  wire logic                irq_pending,
  input  wire logic                carry_wr,
  input  wire logic                carry_wdata,
  input  wire logic                working_wr,
  input  wire logic [7:0]          working_wdata,
  output logic                     busy,
  output logic                     done,
  output logic [ADDR_W-1:0]        mem_addr,
  output logic                     mem_rd,
  output logic                     mem_wr,
  output logic [7:0]               mem_wdata,
  output logic                     stack_pop,
  output logic                     stack_push,
  output logic [PC_W-1:0]          stack_push_data,
  output logic                     pc_load,
  output logic [PC_W-1:0]          pc_value,
  output logic                     irq_ack,
  output logic [7:0]               working_register,
  output logic                     carry_flag,
  output logic                     master_irq_enable
);

  // ----------------------------------------------------------------
  // rotate unit: returns {new carry, result}
  // ----------------------------------------------------------------
  function automatic logic [8:0] rre_rotate(input rre_pkg::rre_op_t op,
                                            input logic [7:0] d,
                                            input logic c);
    logic [8:0] r;
    r = {c, d};
    case (op)
      rre_pkg::RRE_OP_RL_MEM,
      rre_pkg::RRE_OP_RL_WR:   r = {c, d[`RRE_MSB-1:`RRE_LSB], d[`RRE_MSB]};
      rre_pkg::RRE_OP_RLC_MEM,
      rre_pkg::RRE_OP_RLC_WR:  r = {d[`RRE_MSB], d[`RRE_MSB-1:`RRE_LSB], c};
      rre_pkg::RRE_OP_RR_MEM:  r = {c, d[`RRE_LSB], d[`RRE_MSB:`RRE_LSB+1]};
      default:                 r = {c, d};
    endcase
    return r;
  endfunction

  function automatic logic rre_to_mem(input rre_pkg::rre_op_t op);
    return (op == rre_pkg::RRE_OP_RL_MEM) || (op == rre_pkg::RRE_OP_RLC_MEM) ||
           (op == rre_pkg::RRE_OP_RR_MEM);
  endfunction

  function automatic logic rre_is_ret(input rre_pkg::rre_op_t op);
    return (op == rre_pkg::RRE_OP_RET_LIT) || (op == rre_pkg::RRE_OP_RET_IRQ);
  endfunction

  // ----------------------------------------------------------------
  // held operation
  // ----------------------------------------------------------------
  rre_pkg::rre_state_t  state;
  rre_pkg::rre_op_t     cur_op;
  logic [7:0]           cur_imm;
  logic [8:0]           rot;
  logic                 accept;
  logic                 calc;
  logic                 popped;
  logic                 go_irq;

  assign accept = op_valid && (state == rre_pkg::RRE_ST_IDLE) &&
                  (op_code != rre_pkg::RRE_OP_NONE);
  assign calc   = (state == rre_pkg::RRE_ST_CALC);
  assign popped = (state == rre_pkg::RRE_ST_POP);
  // interrupt entry is taken on any pending request at this return; the master enable is not read
  assign go_irq = popped && (cur_op == rre_pkg::RRE_OP_RET_IRQ) && irq_pending;
  assign rot    = rre_rotate(cur_op, mem_rdata, carry_flag);

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cur_op  <= rre_pkg::RRE_OP_NONE;
      cur_imm <= 8'h00;
    end else if (accept) begin
      cur_op  <= op_code;
      cur_imm <= op_imm;
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state <= rre_pkg::RRE_ST_IDLE;
    end else begin
      case (state)
        rre_pkg::RRE_ST_IDLE: begin
          if (accept) begin
            state <= rre_is_ret(op_code) ? rre_pkg::RRE_ST_POP : rre_pkg::RRE_ST_READ;
          end
        end
        rre_pkg::RRE_ST_READ: state <= rre_pkg::RRE_ST_CALC;
        rre_pkg::RRE_ST_CALC: state <= rre_pkg::RRE_ST_IDLE;
        rre_pkg::RRE_ST_POP: begin
          state <= go_irq ? rre_pkg::RRE_ST_IRQ : rre_pkg::RRE_ST_IDLE;
        end
        rre_pkg::RRE_ST_IRQ: state <= rre_pkg::RRE_ST_IDLE;
        default: state <= rre_pkg::RRE_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= (calc) || (popped && !go_irq) || (state == rre_pkg::RRE_ST_IRQ);
      if (accept) begin
        busy <= 1'b1;
      end else if (calc || (popped && !go_irq) || (state == rre_pkg::RRE_ST_IRQ)) begin
        busy <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // data memory port
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      mem_addr  <= '0;
      mem_rd    <= 1'b0;
      mem_wr    <= 1'b0;
      mem_wdata <= 8'h00;
    end else begin
      mem_rd <= accept && !rre_is_ret(op_code);
      mem_wr <= calc && rre_to_mem(cur_op);
      if (accept) begin
        mem_addr <= op_addr;
      end
      if (calc) begin
        mem_wdata <= rot[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // stack and program counter
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      stack_pop       <= 1'b0;
      stack_push      <= 1'b0;
      stack_push_data <= '0;
      pc_load         <= 1'b0;
      pc_value        <= '0;
      irq_ack         <= 1'b0;
    end else begin
      stack_pop  <= accept && rre_is_ret(op_code);
      stack_push <= 1'b0;
      pc_load    <= 1'b0;
      irq_ack    <= 1'b0;
      if (popped) begin
        pc_value <= stack_top;
        pc_load  <= !go_irq;
      end
      if (state == rre_pkg::RRE_ST_IRQ) begin
        // the popped address is saved so the main program resumes after the handler
        stack_push      <= 1'b1;
        stack_push_data <= pc_value;
        pc_value        <= IRQ_VEC[PC_W-1:0];
        pc_load         <= 1'b1;
        irq_ack         <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // working register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      working_register <= `RRE_WR_RST;
    end else if (popped && (cur_op == rre_pkg::RRE_OP_RET_LIT)) begin
      working_register <= cur_imm;
    end else if (calc && !rre_to_mem(cur_op)) begin
      working_register <= rot[7:0];
    end else if (working_wr) begin
      working_register <= working_wdata;
    end
  end

  // ----------------------------------------------------------------
  // carry flag: only the through-carry forms and the carry_wr side write touch it
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      carry_flag <= `RRE_CARRY_RST;
    end else if (calc && ((cur_op == rre_pkg::RRE_OP_RLC_MEM) ||
                          (cur_op == rre_pkg::RRE_OP_RLC_WR))) begin
      carry_flag <= rot[8];
    end else if (carry_wr) begin
      carry_flag <= carry_wdata;
    end
  end

  // ----------------------------------------------------------------
  // master interrupt enable
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      master_irq_enable <= `RRE_MIE_RST;
    end else if (state == rre_pkg::RRE_ST_IRQ) begin
      // entry masks nesting; the handler's own return sets it again
      master_irq_enable <= `RRE_MIE_OFF;
    end else if (popped && (cur_op == rre_pkg::RRE_OP_RET_IRQ)) begin
      master_irq_enable <= `RRE_MIE_ON;
    end
  end

endmodule

`default_nettype wire

// ===== src/rre_map.svh
// constants for the return and rotate execution block
`ifndef RRE_MAP_SVH
`define RRE_MAP_SVH

// ----------------------------------------------------------------
// bit positions of the data byte
// ----------------------------------------------------------------
`define RRE_MSB        7
`define RRE_LSB        0

// ----------------------------------------------------------------
// reset and forced values
// ----------------------------------------------------------------
`define RRE_WR_RST     8'h00
`define RRE_CARRY_RST  1'b0
`define RRE_MIE_RST    1'b0
`define RRE_MIE_ON     1'b1
`define RRE_MIE_OFF    1'b0

// ----------------------------------------------------------------
// default widths and vector
// ----------------------------------------------------------------
`define RRE_PC_W       10
`define RRE_ADDR_W     8
`define RRE_IRQ_VEC    10'h004

`endif

// ===== src/rre_pkg.sv
// types for the return and rotate execution block
`default_nettype none

package rre_pkg;

  // ----------------------------------------------------------------
  // operations accepted from the decoder
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    RRE_OP_RET_LIT  = 3'b000,
    RRE_OP_RET_IRQ  = 3'b001,
    RRE_OP_RL_MEM   = 3'b010,
    RRE_OP_RL_WR    = 3'b011,
    RRE_OP_RLC_MEM  = 3'b100,
    RRE_OP_RLC_WR   = 3'b101,
    RRE_OP_RR_MEM   = 3'b110,
    RRE_OP_NONE     = 3'b111
  } rre_op_t;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    RRE_ST_IDLE = 3'b000,
    RRE_ST_READ = 3'b001,
    RRE_ST_CALC = 3'b010,
    RRE_ST_POP  = 3'b011,
    RRE_ST_IRQ  = 3'b100
  } rre_state_t;

endpackage

`default_nettype wire
